// ---- hdl/hpp_map.svh ----
// hpp_map.svh: constants of the host configuration port
// assumes: included by bare name; definitions only
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH

// bus widths
`define HPP_ADDR_W       11
`define HPP_DATA_W       8

// serial frame layout: rw bit, 4 zero bits, address, then data
`define HPP_RW_POS       15
`define HPP_HDR_BITS     16
`define HPP_WR_BITS      24
`define HPP_RD_BITS      32
`define HPP_DOUT_FIRST   24

// host timing, ns and derived cycles at the system clock
`define HPP_CLK_MHZ      40
`define HPP_SETUP_NS     50
`define HPP_STROBE_NS    500
`define HPP_HOLD_NS      50
`define HPP_SCLK_HALF_NS 100
`define HPP_CYC_UP(ns)   ((((ns) * `HPP_CLK_MHZ) + 999) / 1000)
`define HPP_SETUP_CYC    `HPP_CYC_UP(`HPP_SETUP_NS)
`define HPP_STROBE_CYC   `HPP_CYC_UP(`HPP_STROBE_NS)
`define HPP_HOLD_CYC     `HPP_CYC_UP(`HPP_HOLD_NS)
`define HPP_HALF_CYC     ((`HPP_SCLK_HALF_NS * `HPP_CLK_MHZ) / 1000)

`endif

// ---- hdl/hpp_pkg.sv ----
// hpp_pkg: types shared by both ends of the configuration port
// assumes: hpp_map.svh on the include path
`include "hpp_map.svh"

package hpp_pkg;

    typedef logic [`HPP_ADDR_W-1:0] addr_t;
    typedef logic [`HPP_DATA_W-1:0] data_t;

    // device system-clock side states
    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_WAIT  = 2'b01,
        D_DRIVE = 2'b10,
        D_HOLD  = 2'b11
    } dev_state_e;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] dir_s;
        logic [1:0] stb_s;
        logic [1:0] spi_s;
        logic [1:0] sty_s;
        addr_t      addr_s1;
        addr_t      addr_s2;
        data_t      data_s1;
        data_t      data_s2;
        logic [2:0] tgl_s;
        logic       act_q;
        dev_state_e state;
        logic       par;
        logic       req;
        logic       we;
        addr_t      addr;
        data_t      wdata;
        data_t      rdata;
        logic       drive;
    } dev_core_s;

    // link-clock frame state, cleared by chip select
    typedef struct packed {
        logic [5:0] cnt;
        logic [15:0] hdr;
        data_t      wdata;
    } dev_ser_s;

    // link-clock event carrier, survives chip select
    typedef struct packed {
        logic       tgl;
        logic       rd;
        addr_t      addr;
        data_t      wdata;
    } dev_evt_s;

    typedef enum logic [2:0] {
        H_IDLE   = 3'b000,
        H_SETUP  = 3'b001,
        H_STROBE = 3'b010,
        H_HOLD   = 3'b011,
        H_SHIFT  = 3'b100
    } host_state_e;

    typedef struct packed {
        host_state_e state;
        logic [7:0]  wait_cnt;
        logic [5:0]  bits;
        logic [5:0]  nbits;
        logic        sclk;
        logic [31:0] sh;
        data_t       rx;
        logic        cs_n;
        logic        dir;
        logic        stb;
        addr_t       addr;
        data_t       dout;
        logic        doe;
        logic        rd;
        logic        done;
        logic        spi;
        logic        sty;
        data_t       d_s1;
        data_t       d_s2;
        data_t       rdata;
    } host_s;

endpackage

// ---- hdl/hpp_if.sv ----
// hpp_if: pins between host and device of the configuration port
// assumes: both ends connected; undriven data bits read low
`timescale 1ns/1ps
`include "hpp_map.svh"

interface hpp_if;
    logic                   chip_sel_n;
    logic                   dir_store_serial;
    logic                   strobe_fetch_clk;
    logic                   serial_host_select;
    logic                   bus_style_select;
    logic [`HPP_ADDR_W-1:0] addr;
    logic [`HPP_DATA_W-1:0] host_d;
    logic [`HPP_DATA_W-1:0] host_d_oe;
    logic [`HPP_DATA_W-1:0] dev_d;
    logic [`HPP_DATA_W-1:0] dev_d_oe;
    logic [`HPP_DATA_W-1:0] data;

    // resolved data bus, bit 0 doubles as serial_out_line
    assign data = (dev_d & dev_d_oe) | (host_d & host_d_oe);

    modport dev (
        input  chip_sel_n, dir_store_serial, strobe_fetch_clk,
        input  serial_host_select, bus_style_select, addr, data,
        output dev_d, dev_d_oe
    );

    modport host (
        output chip_sel_n, dir_store_serial, strobe_fetch_clk,
        output serial_host_select, bus_style_select, addr,
        output host_d, host_d_oe,
        input  data
    );
endinterface // hpp_if

// ---- hdl/hpp_dev.sv ----
// hpp_dev: device end of the configuration port
// assumes: acc_ack_i answers each acc_req_o within 8 mclk cycles
`timescale 1ns/1ps
`include "hpp_map.svh"

module hpp_dev (
    // system clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    // pins
    hpp_if.dev                         pins,
    // register access side
    output logic                       acc_req_o,
    output logic                       acc_we_o,
    output hpp_pkg::addr_t             acc_addr_o,
    output hpp_pkg::data_t             acc_wdata_o,
    input  wire logic                  acc_ack_i,
    input  wire hpp_pkg::data_t        acc_rdata_i
);

    hpp_pkg::dev_core_s core_reg, core_next;
    hpp_pkg::dev_ser_s  ser_reg, ser_next;
    hpp_pkg::dev_evt_s  evt_reg, evt_next;
    logic               ser_rst_n;
    logic               sdo_reg, sdo_next;
    logic               ser_oe;
    logic               act;
    logic               rd_req;

    // frame state clears whenever chip select is high
    assign ser_rst_n = rst_n_i & ~pins.chip_sel_n;

    // serial capture on the rising link edge
    always_comb begin
        ser_next = ser_reg;
        evt_next = evt_reg;
        if (ser_reg.cnt < 6'(`HPP_RD_BITS)) begin
            ser_next.cnt = ser_reg.cnt + 6'h01;
        end
        if (ser_reg.cnt < 6'(`HPP_HDR_BITS)) begin
            ser_next.hdr = {ser_reg.hdr[14:0], pins.dir_store_serial}; // RULE6 RULE8
        end else if (ser_reg.cnt < 6'(`HPP_WR_BITS)) begin
            ser_next.wdata = {ser_reg.wdata[6:0], pins.dir_store_serial}; // RULE8
        end
        // header done, read: hand address to the system side
        if (pins.serial_host_select && ser_reg.cnt == 6'(`HPP_HDR_BITS)
                && ser_reg.hdr[`HPP_RW_POS]) begin // RULE1
            evt_next.tgl   = ~evt_reg.tgl;
            evt_next.rd    = 1'b1;
            evt_next.addr  = ser_reg.hdr[`HPP_ADDR_W-1:0];
        end
        // last data bit, write
        if (pins.serial_host_select && ser_reg.cnt == 6'(`HPP_WR_BITS - 1)
                && !ser_reg.hdr[`HPP_RW_POS]) begin
            evt_next.tgl   = ~evt_reg.tgl;
            evt_next.rd    = 1'b0;
            evt_next.addr  = ser_reg.hdr[`HPP_ADDR_W-1:0];
            evt_next.wdata = {ser_reg.wdata[6:0], pins.dir_store_serial};
        end
    end

    always_ff @(posedge pins.strobe_fetch_clk or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            ser_reg <= '0;
        end else begin
            ser_reg <= ser_next;
        end
    end

    // event carrier keeps its toggle across frames
    always_ff @(posedge pins.strobe_fetch_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_reg <= '0;
        end else begin
            evt_reg <= evt_next;
        end
    end

    // read byte out msb first, changed on the falling link edge
    always_comb begin
        sdo_next = sdo_reg;
        if (ser_reg.cnt >= 6'(`HPP_DOUT_FIRST) && ser_reg.cnt < 6'(`HPP_RD_BITS)) begin
            sdo_next = core_reg.rdata[~ser_reg.cnt[2:0]]; // RULE12
        end
    end

    always_ff @(negedge pins.strobe_fetch_clk or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= sdo_next; // RULE7
        end
    end

    // serial output enabled only in the data phase of a read
    assign ser_oe = pins.serial_host_select && !pins.chip_sel_n && ser_reg.hdr[`HPP_RW_POS]
                    && ser_reg.cnt >= 6'(`HPP_DOUT_FIRST); // RULE13

    // parallel strobe decode from synchronised pins
    always_comb begin
        if (core_reg.sty_s[1]) begin
            act    = !core_reg.cs_s[1] && (!core_reg.dir_s[1] || !core_reg.stb_s[1]);
            rd_req = !core_reg.stb_s[1];
        end else begin
            act    = !core_reg.cs_s[1] && !core_reg.stb_s[1];
            rd_req = core_reg.dir_s[1];
        end
    end

    // system side: synchronisers, access sequencing
    always_comb begin
        core_next         = core_reg;
        core_next.cs_s    = {core_reg.cs_s[0], pins.chip_sel_n};
        core_next.dir_s   = {core_reg.dir_s[0], pins.dir_store_serial};
        core_next.stb_s   = {core_reg.stb_s[0], pins.strobe_fetch_clk};
        core_next.spi_s   = {core_reg.spi_s[0], pins.serial_host_select};
        core_next.sty_s   = {core_reg.sty_s[0], pins.bus_style_select};
        core_next.addr_s1 = pins.addr;
        core_next.addr_s2 = core_reg.addr_s1;
        core_next.data_s1 = pins.data;
        core_next.data_s2 = core_reg.data_s1;
        core_next.tgl_s   = {core_reg.tgl_s[1:0], evt_reg.tgl};
        core_next.act_q   = act;
        core_next.req     = 1'b0;
        case (core_reg.state)
            hpp_pkg::D_IDLE: begin
                core_next.drive = 1'b0;
                if (core_reg.spi_s[1] && (core_reg.tgl_s[2] != core_reg.tgl_s[1])) begin
                    core_next.par   = 1'b0;
                    core_next.req   = 1'b1;
                    core_next.we    = !evt_reg.rd;
                    core_next.addr  = evt_reg.addr;
                    core_next.wdata = evt_reg.wdata;
                    core_next.state = hpp_pkg::D_WAIT;
                end else if (!core_reg.spi_s[1] && act && !core_reg.act_q) begin // RULE1
                    core_next.par   = 1'b1;
                    core_next.req   = 1'b1;
                    core_next.we    = !rd_req;
                    core_next.addr  = core_reg.addr_s2; // RULE11
                    core_next.wdata = core_reg.data_s2;
                    core_next.state = hpp_pkg::D_WAIT;
                end
            end
            hpp_pkg::D_WAIT: begin
                if (acc_ack_i) begin
                    if (!core_reg.we) begin
                        core_next.rdata = acc_rdata_i;
                    end
                    if (!core_reg.par) begin
                        core_next.state = hpp_pkg::D_IDLE;
                    end else if (core_reg.we) begin
                        core_next.state = hpp_pkg::D_HOLD;
                    end else begin
                        core_next.state = hpp_pkg::D_DRIVE;
                    end
                end
            end
            hpp_pkg::D_DRIVE: begin
                core_next.drive = act; // RULE13
                if (!act) begin
                    core_next.state = hpp_pkg::D_IDLE;
                end
            end
            hpp_pkg::D_HOLD: begin
                if (!act) begin
                    core_next.state = hpp_pkg::D_IDLE;
                end
            end
            default: begin
                core_next.state = hpp_pkg::D_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_reg <= '{cs_s: 2'h3, stb_s: 2'h3, dir_s: 2'h3, state: hpp_pkg::D_IDLE, default: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    // pin drive: serial bit on d0, or the whole parallel byte
    always_comb begin
        if (ser_oe) begin
            pins.dev_d    = {7'h00, sdo_reg}; // RULE12
            pins.dev_d_oe = 8'h01;
        end else begin
            pins.dev_d    = core_reg.rdata;
            pins.dev_d_oe = {8{core_reg.drive && !pins.chip_sel_n}}; // RULE13
        end
    end

    // access requests
    assign acc_req_o   = core_reg.req;
    assign acc_we_o    = core_reg.we;
    assign acc_addr_o  = core_reg.addr;
    assign acc_wdata_o = core_reg.wdata;

endmodule // hpp_dev

// ---- hdl/hpp_host.sv ----
// hpp_host: host end of the configuration port
// assumes: one access at a time; device answers within the strobe time
//
// How it works
// (RULE1) mode pin high selects serial, low parallel
// (RULE2) single-strobe style: direction high reads, low writes
// (RULE3) single-strobe style: transfer strobe is active low
// (RULE4) split-strobe style: store strobe low writes
// (RULE5) split-strobe style: fetch strobe low reads
// (RULE6) serial: header bits, then write data, shifted in
// (RULE7) serial output changes only on falling clock
// (RULE8) serial input captured on rising clock
// (RULE9) chip select falls per access, held till done
// (RULE10) bus style pin picks parallel strobe style
// (RULE11) eleven address bits, eight data; serial address zero
// (RULE12) serial read data returned on data bit zero
// (RULE13) device leaves bus undriven unless reading
`timescale 1ns/1ps
`include "hpp_map.svh"

module hpp_host #(
    parameter int unsigned SETUP_CYC  = `HPP_SETUP_CYC,
    parameter int unsigned STROBE_CYC = `HPP_STROBE_CYC,
    parameter int unsigned HOLD_CYC   = `HPP_HOLD_CYC,
    parameter int unsigned HALF_CYC   = `HPP_HALF_CYC
) (
    // system clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    // mode straps
    input  wire logic                  spi_mode_i,
    input  wire logic                  split_style_i,
    // access request
    input  wire logic                  req_i,
    input  wire logic                  we_i,
    input  wire hpp_pkg::addr_t        addr_i,
    input  wire hpp_pkg::data_t        wdata_i,
    output logic                       busy_o,
    output logic                       done_o,
    output hpp_pkg::data_t             rdata_o,
    // pins
    hpp_if.host                        pins
);

    hpp_pkg::host_s h_reg, h_next;
    logic           last_wait;
    logic           half_end;

    // shared wait counter end markers
    assign last_wait = (h_reg.wait_cnt == 8'h00);
    assign half_end  = (h_reg.wait_cnt == 8'(HALF_CYC - 1));

    // access sequencer
    always_comb begin
        h_next      = h_reg;
        h_next.d_s1 = pins.data;
        h_next.d_s2 = h_reg.d_s1;
        h_next.done = 1'b0;
        case (h_reg.state)
            hpp_pkg::H_IDLE: begin
                // straps only move between accesses
                h_next.spi  = spi_mode_i; // RULE1
                h_next.sty  = split_style_i; // RULE10
                h_next.sclk = 1'b0;
                // serial strap parks the address bus at zero with it
                if (spi_mode_i) begin
                    h_next.addr = '0; // RULE11
                end
                if (req_i) begin
                    h_next.cs_n = 1'b0; // RULE9
                    h_next.rd   = !we_i;
                    if (h_reg.spi) begin
                        h_next.addr  = '0; // RULE11
                        h_next.doe   = 1'b0;
                        h_next.sh    = {!we_i, 4'h0, addr_i, wdata_i, 8'h00}; // RULE6
                        h_next.nbits = we_i ? 6'(`HPP_WR_BITS) : 6'(`HPP_RD_BITS);
                        h_next.bits  = '0;
                        h_next.wait_cnt = '0;
                        h_next.state = hpp_pkg::H_SHIFT;
                    end else begin
                        h_next.addr  = addr_i; // RULE11
                        h_next.dout  = wdata_i;
                        h_next.doe   = we_i;
                        // single style: direction high reads
                        h_next.dir   = h_reg.sty ? 1'b1 : !we_i; // RULE2
                        h_next.wait_cnt = 8'(SETUP_CYC - 1);
                        h_next.state = hpp_pkg::H_SETUP;
                    end
                end
            end
            hpp_pkg::H_SETUP: begin
                if (last_wait) begin
                    if (!h_reg.sty) begin
                        h_next.stb = 1'b1; // RULE3
                    end else if (h_reg.rd) begin
                        h_next.stb = 1'b1; // RULE5
                    end else begin
                        h_next.dir = 1'b0; // RULE4
                    end
                    h_next.wait_cnt = 8'(STROBE_CYC - 1);
                    h_next.state    = hpp_pkg::H_STROBE;
                end else begin
                    h_next.wait_cnt = h_reg.wait_cnt - 8'h01;
                end
            end
            hpp_pkg::H_STROBE: begin
                if (last_wait) begin
                    // read byte sampled at the end of the strobe
                    if (h_reg.rd) begin
                        h_next.rdata = h_reg.d_s2;
                    end
                    h_next.stb      = 1'b0;
                    h_next.dir      = h_reg.sty ? 1'b1 : h_reg.dir;
                    h_next.wait_cnt = 8'(HOLD_CYC - 1);
                    h_next.state    = hpp_pkg::H_HOLD;
                end else begin
                    h_next.wait_cnt = h_reg.wait_cnt - 8'h01;
                end
            end
            hpp_pkg::H_HOLD: begin
                // chip select stays low through the hold
                if (last_wait) begin
                    h_next.cs_n  = 1'b1; // RULE9
                    h_next.doe   = 1'b0;
                    h_next.done  = 1'b1;
                    h_next.state = hpp_pkg::H_IDLE;
                end else begin
                    h_next.wait_cnt = h_reg.wait_cnt - 8'h01;
                end
            end
            hpp_pkg::H_SHIFT: begin
                if (half_end) begin
                    h_next.wait_cnt = '0;
                    if (h_reg.bits == h_reg.nbits) begin
                        // all bits clocked: end the frame
                        h_next.cs_n  = 1'b1; // RULE9
                        h_next.done  = 1'b1;
                        h_next.rdata = h_reg.rx;
                        h_next.state = hpp_pkg::H_IDLE;
                    end else if (!h_reg.sclk) begin
                        // rising: device captures, host samples d0
                        h_next.sclk = 1'b1; // RULE8
                        h_next.rx   = {h_reg.rx[6:0], h_reg.d_s2[0]}; // RULE12
                        h_next.bits = h_reg.bits + 6'h01;
                    end else begin
                        // falling: next input bit presented
                        h_next.sclk = 1'b0;
                        h_next.sh   = {h_reg.sh[30:0], 1'b0}; // RULE6
                    end
                end else begin
                    h_next.wait_cnt = h_reg.wait_cnt + 8'h01;
                end
            end
            default: begin
                h_next.state = hpp_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            h_reg <= '{cs_n: 1'b1, dir: 1'b1, state: hpp_pkg::H_IDLE, default: '0};
        end else begin
            h_reg <= h_next;
        end
    end

    // pin drive; strobes are active low on the wire
    always_comb begin
        pins.chip_sel_n         = h_reg.cs_n;
        pins.serial_host_select = h_reg.spi; // RULE1
        pins.bus_style_select   = h_reg.sty; // RULE10
        pins.addr               = h_reg.addr;
        pins.host_d             = h_reg.dout;
        pins.host_d_oe          = {8{h_reg.doe}};
        if (h_reg.spi) begin
            pins.dir_store_serial = h_reg.sh[31]; // RULE6
            pins.strobe_fetch_clk = h_reg.sclk;
        end else begin
            pins.dir_store_serial = h_reg.dir; // RULE2 RULE4
            pins.strobe_fetch_clk = !h_reg.stb; // RULE3 RULE5
        end
    end

    // user side
    assign busy_o  = (h_reg.state != hpp_pkg::H_IDLE);
    assign done_o  = h_reg.done;
    assign rdata_o = h_reg.rdata;

endmodule // hpp_host

// ---- testbench/hpp_props.sv ----
// hpp_props: pin-level checks of the configuration port
// assumes: fed from the interface joining host and device
`timescale 1ns/1ps
`include "hpp_map.svh"

module hpp_props #(
    parameter int STROBE_CYC = 20
) (
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    // pins
    input  wire logic                   chip_sel_n,
    input  wire logic                   dir_store_serial,
    input  wire logic                   strobe_fetch_clk,
    input  wire logic                   serial_host_select,
    input  wire logic                   bus_style_select,
    input  wire logic [`HPP_ADDR_W-1:0] addr,
    input  wire logic [`HPP_DATA_W-1:0] host_d_oe,
    input  wire logic [`HPP_DATA_W-1:0] dev_d,
    input  wire logic [`HPP_DATA_W-1:0] dev_d_oe
);
    localparam int STROBE_LAST = STROBE_CYC - 1;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // parallel strobe: start, then full low time, then release
    sequence strobe_start;
        !serial_host_select && $fell(strobe_fetch_clk);
    endsequence
    sequence strobe_body;
        ##STROBE_LAST !strobe_fetch_clk ##1 strobe_fetch_clk;
    endsequence
    sequence deselected;
        chip_sel_n [*5];
    endsequence

    AST_STROBE_LEN: assert property (strobe_start |-> strobe_body)
        else $error("parallel strobe length wrong");
    AST_CS_SPANS_STROBE: assert property (!serial_host_select && !strobe_fetch_clk |-> !chip_sel_n)
        else $error("strobe low outside chip select");
    AST_SPLIT_ONE_STROBE: assert property (!serial_host_select && bus_style_select |-> dir_store_serial || strobe_fetch_clk)
        else $error("both split strobes low");
    AST_HOST_WRITE_DRIVE: assert property (!serial_host_select && !chip_sel_n && !dir_store_serial |-> host_d_oe == 8'hff)
        else $error("host not driving write data");
    AST_NO_CLASH: assert property ((host_d_oe & dev_d_oe) == 8'h00)
        else $error("host and device drive together");
    AST_DEV_QUIET: assert property (deselected |-> dev_d_oe == 8'h00)
        else $error("device drives while deselected");
    AST_DEV_WRITE_QUIET: assert property (!serial_host_select && !chip_sel_n && !dir_store_serial
        |-> dev_d_oe == 8'h00)
        else $error("device drives during a write");
    AST_SER_BIT0: assert property (serial_host_select |-> (dev_d_oe & 8'hfe) == 8'h00)
        else $error("serial drive beyond bit zero");
    AST_SER_ADDR: assert property (serial_host_select |-> addr == '0)
        else $error("address bus not zero in serial");
    AST_SDO_FALL: assert property (serial_host_select && dev_d_oe[0] && $past(dev_d_oe[0]) && $changed(dev_d[0])
        |-> $fell(strobe_fetch_clk))
        else $error("serial output moved off falling clock");
endmodule // hpp_props

// ---- testbench/host_port_pin_protocol_test.sv ----
// host_port_pin_protocol_test: host and device ends joined, all three modes
// assumes: register store modelled here behind the device access side
`timescale 1ns/1ps

module host_port_pin_protocol_test;
    typedef struct packed {logic we; hpp_pkg::addr_t a; hpp_pkg::data_t d;} note_s;
    logic           mclk_i, rst_n_i, spi_mode_i, split_style_i, req_i, we_i, done_o, busy_o;
    logic           acc_req_o, acc_we_o, acc_ack_i;
    hpp_pkg::addr_t addr_i, acc_addr_o, a;
    hpp_pkg::data_t wdata_i, rdata_o, acc_wdata_o, acc_rdata_i, d;
    hpp_pkg::data_t mem [0:2047];
    hpp_pkg::data_t exp_mem [hpp_pkg::addr_t];
    note_s          dev_q[$], done_q[$], nt, nd;
    int             fail_count, comparisons;

    hpp_if link ();
    hpp_host u_hpp_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi_mode_i(spi_mode_i),
        .split_style_i(split_style_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .pins(link.host));
    hpp_dev u_hpp_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins(link.dev), .acc_req_o(acc_req_o),
        .acc_we_o(acc_we_o), .acc_addr_o(acc_addr_o), .acc_wdata_o(acc_wdata_o), .acc_ack_i(acc_ack_i),
        .acc_rdata_i(acc_rdata_i));
    hpp_props #(.STROBE_CYC(20)) u_hpp_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .chip_sel_n(link.chip_sel_n),
        .dir_store_serial(link.dir_store_serial), .strobe_fetch_clk(link.strobe_fetch_clk),
        .serial_host_select(link.serial_host_select), .bus_style_select(link.bus_style_select),
        .addr(link.addr), .host_d_oe(link.host_d_oe), .dev_d(link.dev_d), .dev_d_oe(link.dev_d_oe));

    // system clock
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // register store: ack one cycle after request
    always @(posedge mclk_i) begin
        acc_ack_i <= acc_req_o;
        acc_rdata_i <= mem[acc_addr_o];
        if (acc_req_o === 1'b1 && acc_we_o === 1'b1) mem[acc_addr_o] <= acc_wdata_o;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // output watcher: device requests and host completions against notes
    always @(negedge mclk_i) begin
        if (acc_req_o === 1'b1) begin
            nt = (dev_q.size() != 0) ? dev_q.pop_front() : '1;
            check(32'({acc_we_o, acc_addr_o, nt.we ? acc_wdata_o : nt.d}), 32'(nt));
        end
        if (done_o === 1'b1) begin
            if (done_q.size() == 0) check(32'h1, 32'h0);
            else begin
                nd = done_q.pop_front();
                if (!nd.we) check(32'(rdata_o), 32'(nd.d));
            end
        end
    end

    // one access; poke fires a refused request mid-access
    task automatic access(input logic we, input hpp_pkg::addr_t ta, input hpp_pkg::data_t td, input bit poke);
        int n;
        n = 0;
        if (we) exp_mem[ta] = td;
        dev_q.push_back('{we, ta, exp_mem[ta]});
        done_q.push_back('{we, ta, exp_mem[ta]});
        @(posedge mclk_i);
        req_i <= 1'b1;
        we_i <= we;
        addr_i <= ta;
        wdata_i <= td;
        @(posedge mclk_i);
        req_i <= 1'b0;
        @(negedge mclk_i);
        check(32'(busy_o), 32'h1);
        if (poke) begin
            repeat (3) @(posedge mclk_i);
            req_i <= 1'b1;
            addr_i <= ~ta;
            @(posedge mclk_i);
            req_i <= 1'b0;
        end
        do @(negedge mclk_i); while (done_o !== 1'b1 && ++n < 400);
        if (n >= 400) check(32'h0, 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("counts: comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog, about six times the expected run
    initial begin
        repeat (20000) @(posedge mclk_i);
        check(32'h0, 32'h1);
        tally_and_finish();
    end

    // main sequence: single, split, serial
    initial begin
        {fail_count, comparisons} = '0;
        {rst_n_i, spi_mode_i, split_style_i, req_i, we_i, acc_ack_i} = '0;
        {addr_i, wdata_i, acc_rdata_i} = '0;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h7a19d962));
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk_i);
            spi_mode_i <= (m == 2);
            split_style_i <= (m == 1);
            repeat (3) @(posedge mclk_i);
            access(1'b1, 11'h000, 8'hff, 1'b0);
            access(1'b1, 11'h7ff, 8'h00, 1'b0);
            for (int k = 0; k < 4; k++) begin
                a = hpp_pkg::addr_t'($urandom);
                d = hpp_pkg::data_t'($urandom);
                access(1'b1, a, d, k == 1);
                access(1'b0, a, 8'h00, k == 2);
            end
            access(1'b0, 11'h000, 8'h00, 1'b0);
            access(1'b0, 11'h7ff, 8'h00, 1'b0);
            $display("test mode %0d finished", m);
        end
        tally_and_finish();
    end
endmodule // host_port_pin_protocol_test
